// ---- rtl/actuator_regs.svh ----
`ifndef ACTUATOR_REGS_SVH
`define ACTUATOR_REGS_SVH

// frame geometry
`define FRAME_BITS         24
`define FRAME_LEN          5'h18
`define BITCNT_MAX         5'h1F
`define BITCNT_ZERO        5'h00

// control word zero field positions
`define CTRL_SELECT_BIT    0
`define CTRL_ENABLE_BIT    23
`define CTRL_CLEAR_BIT     22
`define CTRL_DUTY_BIT      21
`define CTRL_RECDIS_BIT    20
`define CTRL_MON_HI_BIT    19
`define CTRL_MON_LO_BIT    18

// fault word zero field positions
`define STAT_ONE_BIT       23
`define STAT_OVERVOLT_BIT  22
`define STAT_UNDERVOLT_BIT 21
`define STAT_THERMAL_BIT   20
`define STAT_WARN_BIT      19
`define STAT_FAULT_BIT     0

// reset value and status word fill constants
`define WORD_RESET         24'h00_0000
`define STAT_ZERO_FILL     18'h0_0000
`define STAT_ONE_FILL      23'h00_0000

`endif

// ---- rtl/actuator_pkg.sv ----
package actuator_pkg;

	// serial link frame tracking
	typedef enum logic {
		LINK_IDLE,
		LINK_FRAME
	} frame_e;

	// fault detector levels from the power stage
	typedef struct packed {
		logic overVolt;
		logic underVolt;
		logic thermalTrip;
		logic heatWarn;
	} fault_in_s;

	typedef logic [23:0] word_t;

endpackage

// ---- rtl/sticky_flag.sv ----
`timescale 1ns/1ps

module sticky_flag (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic ce,
	input  wire logic setIn,
	input  wire logic clrIn,
	output logic      flag
);

	logic flag_next;

	// a set arriving with the clear wins, so no event is lost
	always_comb begin
		flag_next = setIn | (flag & ~clrIn);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flag <= 1'b0;
		end else if (ce) begin
			flag <= flag_next;
		end
	end

endmodule

// ---- rtl/actuator_ctrl_status.sv ----
// Behaviour
// - enable bit 23 written one puts the device in active mode
// - enable written zero, or reset, gives standby with all bits cleared
// - fault word zero bit 23 always reads one
// - clear bit 22 in a valid frame clears both status words at frame end
// - control bit 21 picks retry duty: zero 12 percent, one 25 percent
// - overvoltage or undervoltage sets status 22 or 21 and drops outputs
// - outputs return with supply unless recovery disable bit 20 set
// - thermal trip sets status bit 20 and switches all outputs off
// - outputs stay off until master clears the thermal trip flag
// - heat warning bit 19 is information only, no output effect
// - control bits 19 and 18 select the high side current image
// - only a frame of exactly 24 clocks is written, others discarded
// - first bit in selects control word written and status word returned
// - words travel least significant bit first in both directions
`timescale 1ns/1ps
`include "actuator_regs.svh"

module actuator_ctrl_status
	import actuator_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       ce,
	input  wire logic       frame_select_n,
	input  wire logic       serialClk,
	input  wire logic       serial_in,
	input  wire fault_in_s  faultIn,
	output logic            serialOut,
	output logic            serialOutEn,
	output logic            activeMode,
	output logic            driveEnable,
	output logic            retryDutyHigh,
	output logic [1:0]      currentImageSel,
	output word_t           ctrlZeroWord,
	output word_t           ctrlOneWord,
	output logic            thermal_trip_flag,
	output logic            heat_warning_flag
);

	frame_e     frameState_reg, frameState_next;
	logic       csPrev_reg;
	logic       sclkPrev_reg;
	logic [4:0] bitCnt_reg, bitCnt_next;
	word_t      shiftIn_reg, shiftIn_next;
	word_t      outShift_reg, outShift_next;
	logic       serialOut_next, serialOutEn_next;
	word_t      ctrlZero_next, ctrlOne_next;
	logic       activeMode_next, driveEnable_next, retryDutyHigh_next;
	logic [1:0] currentImageSel_next;
	logic       overVoltFlag, underVoltFlag;
	logic       inFrame, sclkRise, sclkFall, csRise, frameOk;
	logic       wrZero, wrOne, statusClr, faultAny;
	word_t      statusZero, statusOne;

	// edge detection on pins already synchronous to clk
	assign inFrame  = (frameState_reg == LINK_FRAME) & ~frame_select_n;
	assign sclkRise = inFrame & ~sclkPrev_reg & serialClk;
	assign sclkFall = inFrame & sclkPrev_reg & ~serialClk;
	assign csRise   = (frameState_reg == LINK_FRAME) & frame_select_n;
	assign frameOk  = csRise & (bitCnt_reg == `FRAME_LEN);
	assign wrZero   = frameOk & ~shiftIn_reg[`CTRL_SELECT_BIT];
	assign wrOne    = frameOk & shiftIn_reg[`CTRL_SELECT_BIT];
	// standby entry also wipes the status words
	assign statusClr = wrZero & (shiftIn_reg[`CTRL_CLEAR_BIT]
		| ~shiftIn_reg[`CTRL_ENABLE_BIT]);

	// status words as presented on the serial output
	assign faultAny   = overVoltFlag | underVoltFlag | thermal_trip_flag | heat_warning_flag;
	assign statusZero = {1'b1, overVoltFlag, underVoltFlag,
		thermal_trip_flag, heat_warning_flag, `STAT_ZERO_FILL, faultAny};
	assign statusOne  = {`STAT_ONE_FILL, faultAny};

	// sticky status flags; set beats clear inside the flag module
	sticky_flag uOverVolt (
		.clk   (clk),
		.rst_b (rst_b),
		.ce    (ce),
		.setIn (faultIn.overVolt),
		.clrIn (statusClr),
		.flag  (overVoltFlag)
	);
	sticky_flag uUnderVolt (
		.clk   (clk),
		.rst_b (rst_b),
		.ce    (ce),
		.setIn (faultIn.underVolt),
		.clrIn (statusClr),
		.flag  (underVoltFlag)
	);
	sticky_flag uThermal (
		.clk   (clk),
		.rst_b (rst_b),
		.ce    (ce),
		.setIn (faultIn.thermalTrip),
		.clrIn (statusClr),
		.flag  (thermal_trip_flag)
	);
	sticky_flag uHeatWarn (
		.clk   (clk),
		.rst_b (rst_b),
		.ce    (ce),
		.setIn (faultIn.heatWarn),
		.clrIn (statusClr),
		.flag  (heat_warning_flag)
	);

	// link side: frame tracking, lsb-first shift in and out
	always_comb begin
		frameState_next  = frameState_reg;
		bitCnt_next      = bitCnt_reg;
		shiftIn_next     = shiftIn_reg;
		outShift_next    = outShift_reg;
		serialOut_next   = serialOut;
		serialOutEn_next = serialOutEn;
		case (frameState_reg)
			LINK_IDLE: begin
				if (csPrev_reg && !frame_select_n) begin
					frameState_next  = LINK_FRAME;
					bitCnt_next      = `BITCNT_ZERO;
					serialOutEn_next = 1'b1;
					serialOut_next   = faultAny;  // poll fault before any clock
				end
			end
			LINK_FRAME: begin
				if (csRise) begin
					frameState_next  = LINK_IDLE;
					serialOutEn_next = 1'b0;
					serialOut_next   = 1'b0;
				end else if (sclkRise) begin
					shiftIn_next = {serial_in, shiftIn_reg[23:1]};
					if (bitCnt_reg != `BITCNT_MAX) begin
						bitCnt_next = bitCnt_reg + 5'h01;  // saturates, long frames stay bad
					end
					if (bitCnt_reg == `BITCNT_ZERO) begin
						outShift_next  = serial_in ? statusOne : statusZero;
						serialOut_next = serial_in ? statusOne[0] : statusZero[0];
					end
				end else if (sclkFall && bitCnt_reg != `BITCNT_ZERO) begin
					outShift_next  = {1'b0, outShift_reg[23:1]};
					serialOut_next = outShift_reg[1];
				end
			end
			default: begin
				frameState_next = LINK_IDLE;
			end
		endcase
	end

	// control side: commit words at frame end, derive drive permissions
	always_comb begin
		ctrlZero_next = ctrlZeroWord;
		ctrlOne_next  = ctrlOneWord;
		if (wrZero) begin
			if (shiftIn_reg[`CTRL_ENABLE_BIT]) begin
				ctrlZero_next = shiftIn_reg;
			end else begin
				ctrlZero_next = `WORD_RESET;
				ctrlOne_next  = `WORD_RESET;
			end
		end
		if (wrOne) begin
			ctrlOne_next = shiftIn_reg;
		end
		activeMode_next      = ctrlZero_next[`CTRL_ENABLE_BIT];
		retryDutyHigh_next   = ctrlZero_next[`CTRL_DUTY_BIT];
		currentImageSel_next = {ctrlZero_next[`CTRL_MON_HI_BIT],
			ctrlZero_next[`CTRL_MON_LO_BIT]};
		// warning flag is left out on purpose; it never gates drive
		driveEnable_next = ctrlZero_next[`CTRL_ENABLE_BIT]
			& ~faultIn.overVolt & ~faultIn.underVolt
			& ~faultIn.thermalTrip & ~thermal_trip_flag
			& ~(ctrlZero_next[`CTRL_RECDIS_BIT]
				& (overVoltFlag | underVoltFlag));
	end

	// all state registers but the sticky flags; ce low freezes everything
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			frameState_reg  <= LINK_IDLE;
			csPrev_reg      <= 1'b1;
			sclkPrev_reg    <= 1'b0;
			bitCnt_reg      <= `BITCNT_ZERO;
			shiftIn_reg     <= `WORD_RESET;
			outShift_reg    <= `WORD_RESET;
			serialOut       <= 1'b0;
			serialOutEn     <= 1'b0;
			ctrlZeroWord    <= `WORD_RESET;
			ctrlOneWord     <= `WORD_RESET;
			activeMode      <= 1'b0;
			driveEnable     <= 1'b0;
			retryDutyHigh   <= 1'b0;
			currentImageSel <= 2'h0;
		end else if (ce) begin
			frameState_reg  <= frameState_next;
			csPrev_reg      <= frame_select_n;
			sclkPrev_reg    <= serialClk;
			bitCnt_reg      <= bitCnt_next;
			shiftIn_reg     <= shiftIn_next;
			outShift_reg    <= outShift_next;
			serialOut       <= serialOut_next;
			serialOutEn     <= serialOutEn_next;
			ctrlZeroWord    <= ctrlZero_next;
			ctrlOneWord     <= ctrlOne_next;
			activeMode      <= activeMode_next;
			driveEnable     <= driveEnable_next;
			retryDutyHigh   <= retryDutyHigh_next;
			currentImageSel <= currentImageSel_next;
		end
	end

	// checks on committed words and protection behaviour
	sequence seqWriteZero;
		ce && wrZero;
	endsequence

	sequence seqSupplyFault;
		ce && (faultIn.overVolt || faultIn.underVolt);
	endsequence

	AST_ENABLE_ACTIVE: assert property (@(posedge clk) disable iff (!rst_b)
		seqWriteZero and (shiftIn_reg[`CTRL_ENABLE_BIT]) |=> activeMode)
		else $error("enable write did not reach active mode");

	AST_STANDBY_CLEARS: assert property (@(posedge clk) disable iff (!rst_b)
		seqWriteZero and (!shiftIn_reg[`CTRL_ENABLE_BIT])
		|=> !activeMode && ctrlZeroWord == `WORD_RESET && ctrlOneWord == `WORD_RESET
			&& !driveEnable)
		else $error("standby write left bits set");

	AST_TOP_BIT_ONE: assert property (@(posedge clk) disable iff (!rst_b)
		ce && sclkRise && bitCnt_reg == `BITCNT_ZERO && !serial_in |=> outShift_reg[23])
		else $error("status word zero top bit not one");

	AST_CLEAR_STATUS: assert property (@(posedge clk) disable iff (!rst_b)
		seqWriteZero and (shiftIn_reg[`CTRL_CLEAR_BIT] && faultIn == 4'h0)
		|=> !overVoltFlag && !underVoltFlag && !thermal_trip_flag && !heat_warning_flag)
		else $error("status clear left a flag set");

	AST_DUTY_FIELD: assert property (@(posedge clk) disable iff (!rst_b)
		seqWriteZero and (shiftIn_reg[`CTRL_ENABLE_BIT])
		|=> retryDutyHigh == $past(shiftIn_reg[`CTRL_DUTY_BIT]))
		else $error("retry duty does not follow written bit");

	AST_SUPPLY_OFF: assert property (@(posedge clk) disable iff (!rst_b)
		seqSupplyFault |=> !driveEnable && (overVoltFlag || underVoltFlag))
		else $error("supply fault did not drop outputs");

	AST_AUTO_RECOVER: assert property (@(posedge clk) disable iff (!rst_b)
		ce && !csRise && activeMode && !ctrlZeroWord[`CTRL_RECDIS_BIT]
		&& faultIn.overVolt == 1'b0 && faultIn.underVolt == 1'b0
		&& !faultIn.thermalTrip && !thermal_trip_flag |=> driveEnable)
		else $error("outputs did not recover with supply");

	AST_THERMAL_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
		thermal_trip_flag |-> !driveEnable)
		else $error("outputs on while thermal flag set");

	AST_MONITOR_SEL: assert property (@(posedge clk) disable iff (!rst_b)
		seqWriteZero and (shiftIn_reg[`CTRL_ENABLE_BIT])
		|=> currentImageSel == $past(shiftIn_reg[19:18]))
		else $error("monitor select does not follow written bits");

	AST_BAD_FRAME: assert property (@(posedge clk) disable iff (!rst_b)
		ce && csRise && bitCnt_reg != `FRAME_LEN
		|=> $stable(ctrlZeroWord) && $stable(ctrlOneWord))
		else $error("short or long frame changed a control word");

	AST_LSB_FIRST: assert property (@(posedge clk) disable iff (!rst_b)
		ce && sclkRise |=> shiftIn_reg[23] == $past(serial_in))
		else $error("serial input not shifted in lsb first");

endmodule

// ---- tb/spi_master_model.sv ----
`timescale 1ns/1ps

module spi_master_model
	import actuator_pkg::*;
(
	input  wire logic clk,
	output logic      frame_select_n,
	output logic      serialClk,
	output logic      serial_in,
	input  wire logic serialOut,
	input  wire logic serialOutEn
);
	// idle link: deselected, clock low
	initial begin
		frame_select_n = 1'b1;
		serialClk      = 1'b0;
		serial_in      = 1'b0;
	end

	// one frame, lsb first; a count other than 24 gives a frame to be dropped
	task automatic xfer(input word_t txWord, input int nBits, output word_t rxWord);
		rxWord = '0;
		@(negedge clk) frame_select_n = 1'b0;
		repeat (2) @(negedge clk);
		for (int i = 0; i < nBits; i++) begin
			serial_in = txWord[i % 24];
			@(negedge clk) serialClk = 1'b1;
			repeat (2) @(negedge clk);
			// read late in the high phase: the bit settles a cycle after the edge
			// an undriven output reads inverted, so a silent line is caught
			if (i < 24)
				rxWord[i] = serialOutEn ? serialOut : ~serialOut;
			serialClk = 1'b0;
			repeat (2) @(negedge clk);
		end
		frame_select_n = 1'b1;
		serial_in = ~serial_in; // no stale bit left on a released line
		repeat (3) @(negedge clk);
	endtask

	// select without clocks: output shows the fault summary, empty frame is dropped
	task automatic poll(output logic fault, output logic outEn);
		@(negedge clk) frame_select_n = 1'b0;
		repeat (2) @(negedge clk);
		fault = serialOutEn ? serialOut : ~serialOut;
		outEn = serialOutEn;
		frame_select_n = 1'b1;
		repeat (3) @(negedge clk);
	endtask
endmodule

// ---- tb/actuator_ctrl_status_upper_bits_tb.sv ----
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin \
	cmp_count++; \
	if ((got) !== (ex)) begin \
		num_errors++; \
		$display("wrong value %s expected %h seen %h", nm, ex, got); \
	end \
end

module actuator_ctrl_status_upper_bits_tb
	import actuator_pkg::*;
;
	logic       clk, rst_b, ce;
	logic       frame_select_n, serialClk, serial_in, serialOut, serialOutEn;
	logic       activeMode, driveEnable, retryDutyHigh;
	logic       thermal_trip_flag, heat_warning_flag;
	logic [1:0] currentImageSel;
	word_t      ctrlZeroWord, ctrlOneWord, rx;
	fault_in_s  faultIn;
	logic       pollFault, pollEn;
	int         num_errors = 0;
	int         cmp_count = 0;

	actuator_ctrl_status dut (.clk(clk), .rst_b(rst_b), .ce(ce),
		.frame_select_n(frame_select_n), .serialClk(serialClk), .serial_in(serial_in),
		.faultIn(faultIn), .serialOut(serialOut), .serialOutEn(serialOutEn),
		.activeMode(activeMode), .driveEnable(driveEnable), .retryDutyHigh(retryDutyHigh),
		.currentImageSel(currentImageSel), .ctrlZeroWord(ctrlZeroWord),
		.ctrlOneWord(ctrlOneWord), .thermal_trip_flag(thermal_trip_flag),
		.heat_warning_flag(heat_warning_flag));
	spi_master_model m (.clk(clk), .frame_select_n(frame_select_n), .serialClk(serialClk),
		.serial_in(serial_in), .serialOut(serialOut), .serialOutEn(serialOutEn));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// control word zero from its upper fields
	function automatic word_t cw(logic en, clr, duty, rdis, logic [1:0] mon);
		return {en, clr, duty, rdis, mon, 17'h0_0000, 1'b0};
	endfunction

	task automatic wr(input word_t w, input int n = 24);
		m.xfer(w, n, rx);
	endtask

	// one-cycle detector pulse, then a cycle to settle
	task automatic fpulse(input fault_in_s f);
		@(negedge clk) faultIn = f;
		@(negedge clk) faultIn = '0;
		@(negedge clk);
	endtask

	task automatic tdone(input string s);
		$display("test %s finished, mismatches so far %0d", s, num_errors);
	endtask

	task automatic summarize;
		$display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// hang guard, well past the roughly two thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		$display("watchdog expired");
		summarize();
	end

	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		faultIn = '0;
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		repeat (2) @(negedge clk);
		`CHK("activeMode", 1'b0, activeMode)
		m.poll(pollFault, pollEn);
		`CHK("serialOutEn", 1'b1, pollEn)
		`CHK("fault bit", 1'b0, pollFault)
		m.xfer(cw(0, 0, 0, 0, 2'b00), 24, rx);
		`CHK("status zero", 24'h80_0000, rx)
		`CHK("serialOutEn", 1'b0, serialOutEn)
		tdone("reset");
		// every monitor select, both duty values
		for (int k = 0; k < 4; k++) begin
			wr(cw(1, 0, k[0], 0, k[1:0]));
			`CHK("activeMode", 1'b1, activeMode)
			`CHK("retryDutyHigh", k[0], retryDutyHigh)
			`CHK("currentImageSel", k[1:0], currentImageSel)
			`CHK("ctrlZeroWord", cw(1, 0, k[0], 0, k[1:0]), ctrlZeroWord)
		end
		wr(cw(1, 0, 0, 0, 2'b00), 23);
		wr(cw(1, 0, 0, 0, 2'b00), 25);
		`CHK("currentImageSel", 2'b11, currentImageSel)
		`CHK("retryDutyHigh", 1'b1, retryDutyHigh)
		wr(24'h5A_5A5B);
		`CHK("ctrlOneWord", 24'h5A_5A5B, ctrlOneWord)
		`CHK("ctrlZeroWord", cw(1, 0, 1, 0, 2'b11), ctrlZeroWord)
		tdone("frames");
		fpulse(4'b0010);
		`CHK("thermal_trip_flag", 1'b1, thermal_trip_flag)
		`CHK("driveEnable", 1'b0, driveEnable)
		m.poll(pollFault, pollEn);
		`CHK("fault bit", 1'b1, pollFault)
		m.xfer(cw(1, 0, 1, 0, 2'b11), 24, rx);
		`CHK("status zero", 24'h90_0001, rx)
		`CHK("driveEnable", 1'b0, driveEnable)
		m.xfer(24'h00_0001, 24, rx);
		`CHK("status one", 24'h00_0001, rx)
		wr(cw(1, 1, 1, 0, 2'b11));
		`CHK("thermal_trip_flag", 1'b0, thermal_trip_flag)
		`CHK("driveEnable", 1'b1, driveEnable)
		fpulse(4'b0001);
		`CHK("heat_warning_flag", 1'b1, heat_warning_flag)
		`CHK("driveEnable", 1'b1, driveEnable)
		tdone("thermal");
		@(negedge clk) faultIn = 4'b1000;
		@(negedge clk) `CHK("driveEnable", 1'b0, driveEnable)
		faultIn = '0;
		repeat (2) @(negedge clk);
		`CHK("driveEnable", 1'b1, driveEnable)
		m.xfer(cw(1, 0, 1, 0, 2'b11), 24, rx);
		`CHK("status zero", 24'hC8_0001, rx)
		// recovery disabled: outputs wait for an explicit clear
		wr(cw(1, 1, 1, 1, 2'b11));
		fpulse(4'b0100);
		repeat (4) @(negedge clk);
		`CHK("driveEnable", 1'b0, driveEnable)
		m.xfer(cw(1, 1, 1, 1, 2'b11), 24, rx);
		`CHK("status zero", 24'hA0_0001, rx)
		`CHK("driveEnable", 1'b1, driveEnable)
		tdone("supply");
		wr(24'h00_0000);
		`CHK("activeMode", 1'b0, activeMode)
		`CHK("ctrlOneWord", 24'h00_0000, ctrlOneWord)
		`CHK("driveEnable", 1'b0, driveEnable)
		tdone("standby");
		summarize();
	end
endmodule
